//--- sbm_i2cm.sv
// Bus master model that drives one unit's pins through open-drain pulls
`timescale 1ns/10ps
module sbm_i2cm (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_lo,
  output logic      sda_lo,
  output logic      hung
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    hung   = 1'b0;
  end

  // One 80 ns clock pulse; a slave holding the clock low stretches it
  task automatic pulse(output logic smp);
    int n;
    n = 0;
    #20 scl_lo = 1'b0;
    while (!scl && n < 4000) begin
      #1 n++;
    end
    if (n >= 4000) hung = 1'b1;
    #20 smp = sda;
    #20 scl_lo = 1'b1;
    #20;
  endtask

  task automatic start();
    #20 sda_lo = 1'b1;
    #20 scl_lo = 1'b1;
  endtask

  // Data changes only while the clock is low; released lines float high
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      sda_lo = !b[i];
      pulse(d);
    end
    sda_lo = 1'b0;
    pulse(d);
    ack = !d;
  endtask

  task automatic stop();
    sda_lo = 1'b1;
    #20 scl_lo = 1'b0;
    #40 sda_lo = 1'b0;
    #40;
  endtask
endmodule

//--- sbm_pkg.sv
// Shared register map, field layout and constants of the serial bus block
package sbm_pkg;
  localparam int ADDR_W = 16;

  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_RXD     = 14'h1240;
  localparam logic [13:0] IDX_CR1     = 14'h1242;
  localparam logic [13:0] IDX_CR2     = 14'h1243;
  localparam logic [13:0] IDX_ADR     = 14'h1244;
  localparam logic [13:0] UNIT_STRIDE = 14'h0008;
  localparam logic [13:0] IDX_IST     = 14'h1250;
  localparam logic [13:0] IDX_IMSK    = 14'h1251;

  // First control register
  localparam int CR1_BC_MSB  = 7;
  localparam int CR1_BC_LSB  = 5;
  localparam int CR1_ACK     = 4;
  localparam int CR1_SCK_LSB = 0;
  localparam logic [7:0] CR1_RST   = 8'h00;
  localparam logic [7:0] CR1_WMASK = 8'hF7;

  // Second control register (write side)
  localparam int CR2_MST      = 7;
  localparam int CR2_TRX      = 6;
  localparam int CR2_PIN      = 4;
  localparam int CR2_MODE_MSB = 3;
  localparam int CR2_MODE_LSB = 2;
  localparam logic [1:0] SWR_ARM  = 2'b10;
  localparam logic [1:0] SWR_FIRE = 2'b01;

  // Status layout and reset value
  localparam int ST_BB  = 5;
  localparam int ST_PIN = 4;
  localparam logic [7:0] STATUS_RST = 8'h10;

  localparam logic [7:0] ADR_RST     = 8'h00;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [3:0] BITS_BYTE   = 4'h8;
  localparam logic [3:0] ACK_SLOT    = 4'h9;
  localparam logic [3:0] SWR_CYCLES  = 4'h4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SBM_PORT = 2'b00,
    SBM_SIO  = 2'b01,
    SBM_I2C  = 2'b10,
    SBM_RSVD = 2'b11
  } sbm_mode_t;
endpackage

//--- sbm_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/10ps
module sbm_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Idle bus lines are high, so both stages reset high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

//--- sbm_top.sv
// Two-unit serial bus interface with AXI4-Lite registers and interrupt
//
// How it works
// - Out of reset the clock select reads 0 and soft-reset monitor 1.
// - The bus engine runs standard mode only, with no fast mode.
// - Any clock select value is accepted; fast rates are not checked.
// - Reading the second control register returns the unit status.
`timescale 1ns/10ps
module sbm_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sbm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic      [1:0]                bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [sbm_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic      [31:0]               rdata,
  output logic      [1:0]                rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic [1:0]                scl_in,
  output logic      [1:0]                scl_out,
  output logic      [1:0]                scl_oe,
  input  wire logic [1:0]                sda_in,
  output logic      [1:0]                sda_out,
  output logic      [1:0]                sda_oe,
  output logic                           irq
);
  import sbm_pkg::*;

  logic                awhave_r, awhave_nxt, whave_r, whave_nxt;
  logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
  logic [7:0]          wbyte_r, wbyte_nxt;
  logic                wstb_r, wstb_nxt;
  logic                bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [7:0]          cr1_r [2];
  logic [7:0]          cr1_nxt [2];
  logic [7:0]          adr_r [2];
  logic [7:0]          adr_nxt [2];
  logic [1:0]          ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic [1:0]          scl_s, sda_s, cr2_wr, ev, swrmon;
  logic [7:0]          status [2];
  logic [7:0]          rx_data [2];
  logic                aw_ok, w_ok, do_wr, rd_take, wr_on;
  logic [ADDR_W-1:0]   wa;
  logic [7:0]          wb;

  // Register index of a byte address; low two bits are the lane
  function automatic logic [13:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[ADDR_W-1:2];
  endfunction

  function automatic logic unit_reg(input logic [ADDR_W-1:0] a,
                                    input logic [13:0] base,
                                    input int u);
    unit_reg = (reg_idx(a) == base + (u == 1 ? UNIT_STRIDE : 14'h0000));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = 1'b0;
    for (int u = 0; u < 2; u++) begin
      mapped = mapped | unit_reg(a, IDX_RXD, u) | unit_reg(a, IDX_CR1, u)
             | unit_reg(a, IDX_CR2, u) | unit_reg(a, IDX_ADR, u);
    end
    mapped = mapped | (reg_idx(a) == IDX_IST) | (reg_idx(a) == IDX_IMSK);
  endfunction

  sbm_sync #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({scl_in, sda_in}),
    .q       ({scl_s, sda_s})
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_unit
      sbm_unit u_unit (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .scl_s     (scl_s[g]),
        .sda_s     (sda_s[g]),
        .cr2_wr    (cr2_wr[g]),
        .cr2_wdata (wb),
        .own_addr  (adr_r[g][7:1]),
        .ack_en    (cr1_r[g][CR1_ACK]),
        .status    (status[g]),
        .rx_data   (rx_data[g]),
        .swrmon    (swrmon[g]),
        .event_pls (ev[g]),
        .scl_oe    (scl_oe[g]),
        .sda_oe    (sda_oe[g])
      );
      assign cr2_wr[g] = wr_on & unit_reg(wa, IDX_CR2, g);
    end
  endgenerate

  // Address and data may arrive in either order; each is parked until both
  assign awready = ~awhave_r & ~bvalid_r;
  assign wready  = ~whave_r & ~bvalid_r;
  assign aw_ok   = awhave_r | (awvalid & awready);
  assign w_ok    = whave_r | (wvalid & wready);
  assign do_wr   = aw_ok & w_ok & ~bvalid_r;
  assign wa      = awhave_r ? awaddr_r : awaddr;
  assign wb      = whave_r ? wbyte_r : wdata[7:0];
  assign wr_on   = do_wr & (whave_r ? wstb_r : wstrb[0]) & mapped(wa);
  assign rd_take = arvalid & arready;
  assign arready = ~rvalid_r;

  always_comb begin
    awhave_nxt = awhave_r; awaddr_nxt = awaddr_r;
    whave_nxt = whave_r; wbyte_nxt = wbyte_r; wstb_nxt = wstb_r;
    bvalid_nxt = bvalid_r; bresp_nxt = bresp_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      awhave_nxt = 1'b0;
      whave_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (awvalid && awready) begin
        awhave_nxt = 1'b1;
        awaddr_nxt = awaddr;
      end
      if (wvalid && wready) begin
        whave_nxt = 1'b1;
        wbyte_nxt = wdata[7:0];
        wstb_nxt  = wstrb[0];
      end
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r; rdata_nxt = rdata_r; rresp_nxt = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      for (int u = 0; u < 2; u++) begin
        if (unit_reg(araddr, IDX_RXD, u)) begin
          rdata_nxt[7:0] = rx_data[u];
        end
        // Bit 0 reads the soft-reset monitor, not the clock select
        if (unit_reg(araddr, IDX_CR1, u)) begin
          rdata_nxt[7:0] = {cr1_r[u][7:1], swrmon[u]};
        end
        // Control 2 is write-only; its address reads the status
        if (unit_reg(araddr, IDX_CR2, u)) begin
          rdata_nxt[7:0] = status[u];
        end
        if (unit_reg(araddr, IDX_ADR, u)) begin
          rdata_nxt[7:0] = adr_r[u];
        end
      end
      if (reg_idx(araddr) == IDX_IST) begin
        rdata_nxt[1:0] = ist_r;
      end
      if (reg_idx(araddr) == IDX_IMSK) begin
        rdata_nxt[1:0] = imsk_r;
      end
    end
  end

  always_comb begin
    imsk_nxt = imsk_r;
    ist_nxt  = ist_r;
    if (wr_on && reg_idx(wa) == IDX_IMSK) begin
      imsk_nxt = wb[1:0];
    end
    if (wr_on && reg_idx(wa) == IDX_IST) begin
      ist_nxt = ist_r & ~wb[1:0];
    end
    // A request in the clearing cycle survives
    ist_nxt = ist_nxt | ev;
    for (int u = 0; u < 2; u++) begin
      cr1_nxt[u] = cr1_r[u];
      adr_nxt[u] = adr_r[u];
      // Every clock select code is kept, fast ones included
      if (wr_on && unit_reg(wa, IDX_CR1, u)) begin
        cr1_nxt[u] = wb & CR1_WMASK;
      end
      if (wr_on && unit_reg(wa, IDX_ADR, u)) begin
        adr_nxt[u] = wb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awhave_r <= 1'b0; awaddr_r <= '0; whave_r <= 1'b0;
      wbyte_r <= 8'h00; wstb_r <= 1'b0; bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY; rvalid_r <= 1'b0; rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000; ist_r <= 2'b00; imsk_r <= 2'b00;
      for (int u = 0; u < 2; u++) begin
        cr1_r[u] <= CR1_RST;
        adr_r[u] <= ADR_RST;
      end
    end else begin
      awhave_r <= awhave_nxt; awaddr_r <= awaddr_nxt; whave_r <= whave_nxt;
      wbyte_r <= wbyte_nxt; wstb_r <= wstb_nxt; bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt; rvalid_r <= rvalid_nxt; rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt; ist_r <= ist_nxt; imsk_r <= imsk_nxt;
      for (int u = 0; u < 2; u++) begin
        cr1_r[u] <= cr1_nxt[u];
        adr_r[u] <= adr_nxt[u];
      end
    end
  end

  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign irq     = |(ist_r & imsk_r);
  // Open drain: only the enables move, the driven level is always low
  assign scl_out = 2'b00;
  assign sda_out = 2'b00;

  a_reset_select: assert property (@(posedge aclk)
    !aresetn ##1 aresetn |-> cr1_r[0][CR1_SCK_LSB] == 1'b0 && swrmon == 2'b11)
    else $error("clock select or soft-reset monitor wrong after reset");

  a_status_alias: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_take && reg_idx(araddr) == IDX_CR2
    |=> rdata[7:0] == $past(status[0]) && rvalid)
    else $error("control 2 read did not return unit 0 status");

  a_status_reset: assert property (@(posedge aclk)
    !aresetn ##1 aresetn |-> status[0] == STATUS_RST
    && status[1] == STATUS_RST)
    else $error("status not at reset value after reset");

  a_select_kept: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_on && unit_reg(wa, IDX_CR1, 0)
    |=> cr1_r[0] == ($past(wb) & CR1_WMASK))
    else $error("clock select write not stored as given");

  // Busy shows one edge after the synced line falls, so the high level is two samples back
  a_busy_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(status[0][ST_BB]) |-> $past(sda_s[0], 2) && !$past(sda_s[0]))
    else $error("busy raised without start condition");

  a_stretch_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    scl_oe[0] |-> !status[0][ST_PIN])
    else $error("clock held low without pending request");

  a_ack_busy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sda_oe[0] |-> status[0][ST_BB])
    else $error("acknowledge driven while bus is idle");

  a_event_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[0] |=> ist_r[0] && (!imsk_r[0] || irq))
    else $error("bus event did not set interrupt status");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before handshake");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> bvalid ##0 (bresp == (mapped($past(wa)) ? RESP_OKAY
                                                      : RESP_SLVERR)))
    else $error("write answer missing or wrong");

  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) ##1 1'b1)
    else $error("read data changed before handshake");

  c_status_read: cover property (@(posedge aclk) disable iff (!aresetn)
    rd_take && reg_idx(araddr) == IDX_CR2);
  c_event_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    ev[0] ##1 irq);
  c_soft_reset: cover property (@(posedge aclk) disable iff (!aresetn)
    !swrmon[0]);
  c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
    bvalid && bresp == RESP_SLVERR);
  c_addr_match: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(status[0][2]));
endmodule

//--- sbm_top_tb.sv
// Self-checking bench for the two-unit serial bus block
`timescale 1ns/10ps
module sbm_top_tb;
  import sbm_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready;
  logic              arvalid, rready, awready, wready, bvalid;
  logic              arready, rvalid, irq, ack;
  logic              m_scl_lo, m_sda_lo, m_hung, scl_w, sda_w;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, scl_in, sda_in, scl_oe, sda_oe;
  logic [1:0]        scl_o, sda_o;
  int                err_count, n_checks;

  // Both lines carry pull-ups; unit 1 has no other party on its pins
  assign scl_w  = !(m_scl_lo | scl_oe[0]);
  assign sda_w  = !(m_sda_lo | sda_oe[0]);
  assign scl_in = {!scl_oe[1], scl_w};
  assign sda_in = {!sda_oe[1], sda_w};

  sbm_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'b000), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'b000),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_o), .sda_oe(sda_oe),
    .irq(irq));

  sbm_i2cm mst (.scl(scl_w), .sda(sda_w), .scl_lo(m_scl_lo),
    .sda_lo(m_sda_lo), .hung(m_hung));

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [13:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      n++;
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) err_count++;
    if (!b) wrap_up();
    chk(r, er);
  endtask

  task automatic axr(input logic [13:0] idx, input logic [7:0] ed,
                     input logic [7:0] m, input logic [1:0] er);
    logic a, b;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50) begin
      @(negedge aclk);
      a = arvalid && arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      n++;
      if (a) arvalid <= 1'b0;
      if (b) rready <= 1'b0;
    end
    if (!b) err_count++;
    if (!b) wrap_up();
    chk(r, er);
    if (er === RESP_OKAY) chk(d & {24'h00_0000, m}, {24'h00_0000, ed & m});
  endtask

  task automatic cirq(input logic e);
    @(negedge aclk);
    chk(irq, e);
  endtask

  task automatic t_reset();
    axr(IDX_CR1, 8'h01, 8'hFF, RESP_OKAY);
    axr(IDX_CR2, STATUS_RST, 8'hFF, RESP_OKAY);
    axr(IDX_CR1 + UNIT_STRIDE, 8'h01, 8'hFF, RESP_OKAY);
    axr(IDX_CR2 + UNIT_STRIDE, STATUS_RST, 8'hFF, RESP_OKAY);
    cirq(1'b0);
    chk({scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
  endtask

  // Clock select above the standard rate is stored; bit 0 shows the monitor
  task automatic t_regs();
    axw(IDX_CR1, 8'hFF, RESP_OKAY);
    axr(IDX_CR1, 8'hF7, 8'hFF, RESP_OKAY);
    axw(IDX_CR1, 8'h16, RESP_OKAY);
    axr(IDX_CR1, 8'h17, 8'hFF, RESP_OKAY);
    // Soft reset lasts four cycles; the first read lands inside it
    axw(IDX_CR2, 8'h02, RESP_OKAY);
    axw(IDX_CR2, 8'h01, RESP_OKAY);
    axr(IDX_CR1, 8'h16, 8'hFF, RESP_OKAY);
    axr(IDX_CR1, 8'h17, 8'hFF, RESP_OKAY);
  endtask

  task automatic t_modes();
    axw(IDX_CR2, 8'h14, RESP_OKAY);
    axr(IDX_CR2, STATUS_RST, 8'hFF, RESP_OKAY);
    chk({scl_w, sda_w}, 2'b11);
    axw(IDX_CR2, 8'h18, RESP_OKAY);
    axr(IDX_CR2, STATUS_RST, 8'hFF, RESP_OKAY);
    axw(IDX_ADR, 8'hA0, RESP_OKAY);
    axw(IDX_IMSK, 8'h01, RESP_OKAY);
  endtask

  task automatic t_receive();
    mst.start();
    axr(IDX_CR2, 8'h20, 8'h20, RESP_OKAY);
    mst.wbyte(8'hA0, ack);
    chk(ack, 1'b1);
    axr(IDX_CR2, 8'h24, 8'hFF, RESP_OKAY);
    chk(scl_oe, 2'b01);
    cirq(1'b1);
    axw(IDX_IMSK, 8'h00, RESP_OKAY);
    cirq(1'b0);
    axw(IDX_IMSK, 8'h01, RESP_OKAY);
    cirq(1'b1);
    axw(IDX_CR2, 8'h18, RESP_OKAY);
    mst.wbyte(8'h5A, ack);
    chk(ack, 1'b1);
    axr(IDX_RXD, 8'h5A, 8'hFF, RESP_OKAY);
    axw(IDX_IST, 8'h01, RESP_OKAY);
    cirq(1'b0);
    axw(IDX_CR2, 8'h18, RESP_OKAY);
    mst.stop();
    axr(IDX_CR2, 8'h00, 8'h20, RESP_OKAY);
    axw(IDX_CR2, 8'h10, RESP_OKAY);
    chk(m_hung, 1'b0);
    chk({scl_oe, sda_oe}, 4'h0);
  endtask

  task automatic t_bad();
    axw(14'h1000, 8'h55, RESP_SLVERR);
    axr(14'h1000, 8'h00, 8'h00, RESP_SLVERR);
  endtask

  initial begin
    err_count = 0;
    n_checks  = 0;
    aresetn   = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0_0000;
    awaddr = '0;
    araddr = '0;
    wdata  = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_receive();
    t_bad();
    wrap_up();
  end

  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
endmodule

//--- sbm_unit.sv
// One bus unit: mode control, soft reset and addressed-slave receive engine
`timescale 1ns/10ps
module sbm_unit (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  input  wire logic       cr2_wr,
  input  wire logic [7:0] cr2_wdata,
  input  wire logic [6:0] own_addr,
  input  wire logic       ack_en,
  output logic      [7:0] status,
  output logic      [7:0] rx_data,
  output logic            swrmon,
  output logic            event_pls,
  output logic            scl_oe,
  output logic            sda_oe
);
  import sbm_pkg::*;

  sbm_mode_t  mode_r, mode_nxt;
  logic       mst_r, mst_nxt, trx_r, trx_nxt, bb_r, bb_nxt;
  logic       pin_r, pin_nxt, al_r, al_nxt, aas_r, aas_nxt;
  logic       ad0_r, ad0_nxt, lrb_r, lrb_nxt, first_r, first_nxt;
  logic       ack_r, ack_nxt, arm_r, arm_nxt, scl_q_r, sda_q_r;
  logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
  logic [3:0] bit_r, bit_nxt, swr_r, swr_nxt;
  logic       rise, fall, start, stop, i2c, hit;

  assign rise  = scl_s & ~scl_q_r;
  assign fall  = ~scl_s & scl_q_r;
  assign start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign i2c   = (mode_r == SBM_I2C);
  assign hit   = (sh_r[7:1] == own_addr) || (sh_r[7:1] == GCALL_ADDR);

  always_comb begin
    mode_nxt = mode_r; mst_nxt = mst_r; trx_nxt = trx_r; bb_nxt = bb_r;
    pin_nxt = pin_r; al_nxt = al_r; aas_nxt = aas_r; ad0_nxt = ad0_r;
    lrb_nxt = lrb_r; first_nxt = first_r; ack_nxt = ack_r; arm_nxt = arm_r;
    sh_nxt = sh_r; rx_nxt = rx_r; bit_nxt = bit_r; swr_nxt = swr_r;
    if (cr2_wr) begin
      mode_nxt = sbm_mode_t'(cr2_wdata[CR2_MODE_MSB:CR2_MODE_LSB]);
      trx_nxt  = cr2_wdata[CR2_TRX];
      // Claiming mastership on a busy bus loses arbitration at once
      if (cr2_wdata[CR2_MST] && bb_r && !mst_r) begin
        al_nxt  = 1'b1;
        mst_nxt = 1'b0;
      end else begin
        al_nxt  = 1'b0;
        mst_nxt = cr2_wdata[CR2_MST];
      end
      if (cr2_wdata[CR2_PIN]) begin
        pin_nxt = 1'b1;
      end
      if (cr2_wdata[1:0] == SWR_ARM) begin
        arm_nxt = 1'b1;
      end else if (cr2_wdata[1:0] == SWR_FIRE && arm_r) begin
        arm_nxt = 1'b0;
        swr_nxt = SWR_CYCLES;
      end
    end
    // One sample per clock and no spike filter: standard mode only
    if (i2c) begin
      if (start) begin
        bb_nxt = 1'b1; first_nxt = 1'b1; bit_nxt = '0;
        aas_nxt = 1'b0; ad0_nxt = 1'b0; ack_nxt = 1'b0;
      end else if (stop) begin
        bb_nxt = 1'b0; bit_nxt = '0; aas_nxt = 1'b0;
        ad0_nxt = 1'b0; ack_nxt = 1'b0; mst_nxt = 1'b0;
      end else if (bb_r && rise && bit_r < BITS_BYTE) begin
        sh_nxt  = {sh_r[6:0], sda_s};
        lrb_nxt = sda_s;
        bit_nxt = bit_r + 4'h1;
      end else if (bb_r && fall && bit_r == BITS_BYTE) begin
        bit_nxt = ACK_SLOT;
        if (first_r) begin
          aas_nxt = hit;
          ad0_nxt = (sh_r[7:1] == GCALL_ADDR);
          ack_nxt = hit & ack_en;
        end else begin
          if (aas_r) begin
            rx_nxt = sh_r;
          end
          ack_nxt = aas_r & ack_en;
        end
      end else if (bb_r && fall && bit_r == ACK_SLOT) begin
        bit_nxt = '0; first_nxt = 1'b0; ack_nxt = 1'b0;
        // Hardware request wins over a release written this cycle
        if (aas_r) begin
          pin_nxt = 1'b0;
        end
      end
    end
    if (swr_r != 4'h0) begin
      swr_nxt = swr_r - 4'h1;
      mst_nxt = 1'b0; trx_nxt = 1'b0; bb_nxt = 1'b0; pin_nxt = 1'b1;
      al_nxt = 1'b0; aas_nxt = 1'b0; ad0_nxt = 1'b0; lrb_nxt = 1'b0;
      ack_nxt = 1'b0; bit_nxt = '0; first_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= SBM_PORT; mst_r <= 1'b0; trx_r <= 1'b0; bb_r <= 1'b0;
      pin_r <= 1'b1; al_r <= 1'b0; aas_r <= 1'b0; ad0_r <= 1'b0;
      lrb_r <= 1'b0; first_r <= 1'b0; ack_r <= 1'b0; arm_r <= 1'b0;
      sh_r <= 8'h00; rx_r <= 8'h00; bit_r <= 4'h0; swr_r <= 4'h0;
      scl_q_r <= 1'b1; sda_q_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt; mst_r <= mst_nxt; trx_r <= trx_nxt;
      bb_r <= bb_nxt; pin_r <= pin_nxt; al_r <= al_nxt; aas_r <= aas_nxt;
      ad0_r <= ad0_nxt; lrb_r <= lrb_nxt; first_r <= first_nxt;
      ack_r <= ack_nxt; arm_r <= arm_nxt; sh_r <= sh_nxt; rx_r <= rx_nxt;
      bit_r <= bit_nxt; swr_r <= swr_nxt;
      scl_q_r <= scl_s; sda_q_r <= sda_s;
    end
  end

  // Status bits from 7 down to 0
  assign status    = {mst_r, trx_r, bb_r, pin_r, al_r, aas_r, ad0_r, lrb_r};
  assign rx_data   = rx_r;
  assign swrmon    = (swr_r == 4'h0);
  assign event_pls = pin_r & ~pin_nxt;
  // Clock held low while an addressed transfer waits for software
  assign scl_oe    = i2c & aas_r & ~pin_r;
  assign sda_oe    = i2c & ack_r;
endmodule
